//--- snfe_pkg.sv
package snfe_pkg;

	// Opcodes recognised by the front end
	localparam logic [7:0] OP_RD_ARRAY  = 8'h13;
	localparam logic [7:0] OP_RD_BUF    = 8'h03;
	localparam logic [7:0] OP_RD_BUF_F  = 8'h0B;
	localparam logic [7:0] OP_RD_BUF_X2 = 8'h3B;
	localparam logic [7:0] OP_RD_BUF_X4 = 8'h6B;
	localparam logic [7:0] OP_PRG_LOAD  = 8'h02;
	localparam logic [7:0] OP_PRG_RAND  = 8'h84;
	localparam logic [7:0] OP_PRG_EXEC  = 8'h10;
	localparam logic [7:0] OP_BLK_ERASE = 8'hD8;
	localparam logic [7:0] OP_SET_FEAT  = 8'h1F;
	localparam logic [7:0] OP_GET_FEAT  = 8'h0F;

	// Lock feature word
	localparam logic [7:0] FEAT_LOCK_ADDR  = 8'hA0;
	localparam logic [7:0] FEAT_LOCK_RST   = 8'h00;
	localparam logic [7:0] FEAT_GUARD_MASK = 8'hB8;
	localparam int         LOCK_GUARD_POS  = 7;

	// Geometry
	localparam int ROW_W   = 17;
	localparam int BLOCK_W = 11;
	localparam int PAGE_W  = 6;
	localparam int COL_W   = 13;
	localparam logic [12:0] PAGE_LEN_ECC   = 13'd4224;
	localparam logic [12:0] PAGE_LEN_NOECC = 13'd4352;
	localparam logic [12:0] MAIN_LEN       = 13'd4096;
	localparam logic [12:0] SPARE_ECC      = 13'd128;
	localparam logic [12:0] SPARE_NOECC    = 13'd256;

	// Address bytes per command class
	localparam logic [1:0] ROW_BYTES  = 2'd3;
	localparam logic [1:0] COL_BYTES  = 2'd2;
	localparam logic [1:0] FEAT_BYTES = 2'd1;

	// Write path buffer
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [2:0] {
		SNFE_IDLE  = 3'b000,
		SNFE_OPC   = 3'b001,
		SNFE_ADDR  = 3'b011,
		SNFE_DUMMY = 3'b010,
		SNFE_DOUT  = 3'b110,
		SNFE_DIN   = 3'b111
	} snfe_state_t;

	typedef enum logic [2:0] {
		CL_NONE, CL_ROW, CL_RDBUF, CL_WRBUF, CL_SETF, CL_GETF
	} snfe_class_t;

	typedef struct packed {
		logic [BLOCK_W-1:0] block_num;
		logic [PAGE_W-1:0]  page_num;
	} snfe_row_t;

	typedef struct packed {
		logic [7:0]       opcode;
		logic             has_row;
		logic             has_col;
		snfe_row_t        row_address;
		logic [COL_W-1:0] column_address;
		logic             col_range_err;
	} snfe_cmd_t;

	typedef struct packed {
		logic [COL_W-1:0] column_address;
		logic [7:0]       data;
	} snfe_wr_t;

endpackage : snfe_pkg

//--- snfe_top.sv
// Overview of operation
// - Sample on SCK rise, drive on fall
// - Hold freezes bit position and state, except in quad output
// - Hold starts at a falling SCK edge
// - Outputs float while held, resume after
// - Guard pin low locks guarded lock bits when lock bit 7 is set
// - Hold and guard inputs idle high
// - Lanes: in=0, out=1, guard=2, hold=3
// - Program per page, erase per block
// - ECC on: 4224 byte page, 128 spare
// - ECC off: 4352 byte page, 256 spare
// - Row is 11 block plus 6 page bits
// - Column is 13 bits within page
// - Erase-type commands take row only
`timescale 1ns/10ps

module snfe_fifo
	import snfe_pkg::*;
#(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

	// Shift structure keeps the head in a flop for a clean output
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [CW-1:0]    cnt_r;
	logic [CW-1:0]    cnt_nxt;
	logic             full_r;
	logic             push;
	logic             pop;
	logic [CW-1:0]    wr_idx;

	assign push     = in_valid & ~full_r;
	assign pop      = out_valid & out_ready;
	assign wr_idx   = pop ? cnt_r - CW'(1) : cnt_r;
	assign cnt_nxt  = cnt_r + CW'(push) - CW'(pop);
	assign in_ready = ~full_r;
	assign out_data = mem_r[0];

	always_ff @(posedge clk) begin
		if (srst) begin
			cnt_r     <= '0;
			full_r    <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			cnt_r     <= cnt_nxt;
			full_r    <= (cnt_nxt == FULL_CNT);
			out_valid <= (cnt_nxt != '0);
		end
	end

	always_ff @(posedge clk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (push && (CW'(i) == wr_idx)) begin
				mem_r[i] <= in_data;
			end else if (pop && (i < DEPTH - 1)) begin
				mem_r[i] <= mem_r[i+1];
			end
		end
	end
endmodule : snfe_fifo

module snfe_top
	import snfe_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       SRST,
	input  wire logic       CS_N,
	input  wire logic       SCK,
	input  wire logic       SI_I,
	output logic            SI_O,
	output logic            SI_OE,
	output logic            SO_O,
	output logic            SO_OE,
	input  wire logic       WP_N_I,
	output logic            WP_N_O,
	output logic            WP_N_OE,
	input  wire logic       HOLD_N_I,
	output logic            HOLD_N_O,
	output logic            HOLD_N_OE,
	input  wire logic       ECC_EN,
	output logic            CMD_VALID,
	output snfe_cmd_t       CMD,
	output logic            WR_VALID,
	input  wire logic       WR_READY,
	output snfe_wr_t        WR,
	output logic            WR_OVERRUN,
	input  wire logic       RD_VALID,
	output logic            RD_READY,
	input  wire logic [7:0] RD_DATA,
	output logic [7:0]      LOCK_FEAT
);
	function automatic snfe_class_t op_class(input logic [7:0] op);
		snfe_class_t c;
		c = CL_NONE;
		if (op == OP_RD_ARRAY || op == OP_PRG_EXEC || op == OP_BLK_ERASE)
			c = CL_ROW;
		else if (op == OP_RD_BUF || op == OP_RD_BUF_F ||
			op == OP_RD_BUF_X2 || op == OP_RD_BUF_X4)
			c = CL_RDBUF;
		else if (op == OP_PRG_LOAD || op == OP_PRG_RAND)
			c = CL_WRBUF;
		else if (op == OP_SET_FEAT)
			c = CL_SETF;
		else if (op == OP_GET_FEAT)
			c = CL_GETF;
		return c;
	endfunction : op_class

	function automatic logic [1:0] addr_bytes(input snfe_class_t c);
		logic [1:0] n;
		n = '0;
		case (c)
			CL_ROW:             n = ROW_BYTES;
			CL_RDBUF, CL_WRBUF: n = COL_BYTES;
			CL_SETF, CL_GETF:   n = FEAT_BYTES;
			default:            n = '0;
		endcase
		return n;
	endfunction : addr_bytes

	// Two-stage synchronisers; stage one feeds stage two only
	logic [4:0] sy1_r;
	logic [4:0] sy2_r;
	logic       sck_d_r;
	logic       cs_d_r;
	logic       sck_s, cs_n_s, si_s, wp_n_s, hold_n_s;

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			sy1_r   <= 5'h1F;
			sy2_r   <= 5'h1F;
			sck_d_r <= 1'b0;
			cs_d_r  <= 1'b1;
		end else begin
			sy1_r   <= {SCK, CS_N, SI_I, WP_N_I, HOLD_N_I};
			sy2_r   <= sy1_r;
			sck_d_r <= sck_s;
			cs_d_r  <= cs_n_s;
		end
	end

	assign {sck_s, cs_n_s, si_s, wp_n_s, hold_n_s} = sy2_r;

	snfe_state_t      state_r;
	snfe_class_t      class_r;
	logic [7:0]       opcode_r;
	logic [7:0]       rx_sh_r;
	logic [2:0]       bit_cnt_r;
	logic [1:0]       byte_cnt_r;
	logic [23:0]      addr_r;
	logic [COL_W-1:0] col_r;
	logic [7:0]       feat_addr_r;
	logic [7:0]       lock_r;
	logic             wp_lat_r;
	logic             hold_act_r;
	logic [2:0]       lane_w_r;
	logic [7:0]       out_sh_r;
	logic [2:0]       out_cnt_r;
	logic             dout_on_r;
	logic             push_r;
	snfe_wr_t         push_word_r;

	// Hold pin is a data lane in quad output, so it cannot suspend then
	wire quad_out  = (state_r == SNFE_DOUT) && (lane_w_r == 3'd4);
	wire hold_req  = ~hold_n_s & ~quad_out;
	wire cs_fall   = cs_d_r & ~cs_n_s;
	wire cs_rise   = ~cs_d_r & cs_n_s;
	wire rise_raw  = sck_s & ~sck_d_r & ~cs_n_s;
	wire fall_raw  = ~sck_s & sck_d_r & ~cs_n_s;
	wire sck_rise  = rise_raw & ~hold_act_r;
	wire sck_fall  = fall_raw & ~hold_act_r & ~hold_req;
	wire [7:0] rx_byte  = {rx_sh_r[6:0], si_s};
	wire       byte_done = sck_rise && (bit_cnt_r == 3'd7);
	wire [1:0] need_b    = addr_bytes(class_r);
	wire       addr_last = (byte_cnt_r == need_b - 2'd1);
	wire [23:0] addr_full = {addr_r[15:0], rx_byte};
	wire snfe_class_t opc_cls = op_class(rx_byte);

	// Page length follows the ECC switch; spare grows when ECC is off
	wire [12:0] spare_len = ECC_EN ? SPARE_ECC : SPARE_NOECC;
	wire [12:0] page_len  = MAIN_LEN + spare_len;
	wire        col_ok    = (col_r < page_len);
	wire [COL_W-1:0] col_rx = addr_full[COL_W-1:0];

	// Row fields; erase names a whole block, page bits forced to zero
	wire snfe_row_t row_rx = addr_full[ROW_W-1:0];
	wire is_erase = (opcode_r == OP_BLK_ERASE);
	wire snfe_row_t row_cmd = '{block_num: row_rx.block_num,
		page_num: is_erase ? '0 : row_rx.page_num};

	// Guard pin latched at select so mid-frame wiggles cannot unlock
	wire guard_on = ~wp_lat_r & lock_r[LOCK_GUARD_POS];
	wire [7:0] lock_wr = guard_on ?
		((lock_r & FEAT_GUARD_MASK) | (rx_byte & ~FEAT_GUARD_MASK)) :
		rx_byte;

	wire is_getf  = (class_r == CL_GETF);
	wire [7:0] feat_rd = (feat_addr_r == FEAT_LOCK_ADDR) ? lock_r : 8'h00;
	wire [7:0] rd_byte = RD_VALID ? RD_DATA : 8'hFF;
	wire [7:0] nxt_byte = is_getf ? feat_rd : rd_byte;
	wire       load_out = sck_fall && (state_r == SNFE_DOUT) &&
		(out_cnt_r == 3'd0);
	wire [7:0] cur_out = (out_cnt_r == 3'd0) ? nxt_byte : out_sh_r;
	wire [2:0] opc_w = (opcode_r == OP_RD_BUF_X4) ? 3'd4 :
		(opcode_r == OP_RD_BUF_X2) ? 3'd2 : 3'd1;

	logic fifo_ready;

	// Transaction sequencer
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			state_r     <= SNFE_IDLE;
			class_r     <= CL_NONE;
			opcode_r    <= 8'h00;
			rx_sh_r     <= 8'h00;
			bit_cnt_r   <= 3'd0;
			byte_cnt_r  <= 2'd0;
			addr_r      <= 24'h0000_00;
			col_r       <= '0;
			feat_addr_r <= 8'h00;
			lock_r      <= FEAT_LOCK_RST;
			wp_lat_r    <= 1'b1;
			lane_w_r    <= 3'd1;
			CMD_VALID   <= 1'b0;
			CMD         <= '0;
			push_r      <= 1'b0;
			push_word_r <= '0;
			WR_OVERRUN  <= 1'b0;
		end else begin
			CMD_VALID  <= 1'b0;
			push_r     <= 1'b0;
			WR_OVERRUN <= 1'b0;
			if (sck_rise) begin
				rx_sh_r   <= rx_byte;
				bit_cnt_r <= bit_cnt_r + 3'd1;
			end
			if (cs_rise) begin
				state_r <= SNFE_IDLE;
			end else if (cs_fall) begin
				state_r    <= SNFE_OPC;
				bit_cnt_r  <= 3'd0;
				byte_cnt_r <= 2'd0;
				wp_lat_r   <= wp_n_s;
			end else if (byte_done) begin
				case (state_r)
					SNFE_OPC: begin
						opcode_r <= rx_byte;
						class_r  <= opc_cls;
						if (opc_cls == CL_NONE) begin
							CMD_VALID <= 1'b1;
							CMD       <= '{opcode: rx_byte, default: '0};
							state_r   <= SNFE_IDLE;
						end else begin
							state_r <= SNFE_ADDR;
						end
					end
					SNFE_ADDR: begin
						addr_r     <= addr_full;
						byte_cnt_r <= byte_cnt_r + 2'd1;
						if (addr_last) begin
							byte_cnt_r <= 2'd0;
							col_r      <= col_rx;
							feat_addr_r <= rx_byte;
							lane_w_r   <= opc_w;
							case (class_r)
								CL_ROW: begin
									CMD_VALID <= 1'b1;
									CMD <= '{opcode: opcode_r, has_row: 1'b1,
										has_col: 1'b0, row_address: row_cmd,
										column_address: '0,
										col_range_err: 1'b0};
									state_r <= SNFE_IDLE;
								end
								CL_RDBUF, CL_WRBUF: begin
									CMD_VALID <= 1'b1;
									CMD <= '{opcode: opcode_r, has_row: 1'b0,
										has_col: 1'b1, row_address: '0,
										column_address: col_rx,
										col_range_err: (col_rx >= page_len)};
									state_r <= (class_r == CL_RDBUF) ?
										SNFE_DUMMY : SNFE_DIN;
								end
								CL_GETF: state_r <= SNFE_DOUT;
								default: state_r <= SNFE_DIN;
							endcase
						end
					end
					SNFE_DUMMY: begin
						state_r <= SNFE_DOUT;
					end
					SNFE_DIN: begin
						if (class_r == CL_SETF) begin
							if (feat_addr_r == FEAT_LOCK_ADDR)
								lock_r <= lock_wr;
							state_r <= SNFE_IDLE;
						end else begin
							// Bytes past the page end are dropped
							if (col_ok) begin
								col_r <= col_r + 13'd1;
								if (fifo_ready) begin
									push_r      <= 1'b1;
									push_word_r <= '{column_address: col_r,
										data: rx_byte};
								end else begin
									WR_OVERRUN <= 1'b1;
								end
							end
						end
					end
					default: begin
						state_r <= state_r;
					end
				endcase
			end
		end
	end

	// Hold tracking: begins on a low clock edge, ends once pin is high with clock low
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			hold_act_r <= 1'b0;
		end else if (cs_n_s) begin
			hold_act_r <= 1'b0;
		end else if (fall_raw && hold_req) begin
			hold_act_r <= 1'b1;
		end else if (!hold_req && !sck_s) begin
			hold_act_r <= 1'b0;
		end
	end

	// Output shifter: falling edges launch bits on the active lanes
	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			out_sh_r  <= 8'h00;
			out_cnt_r <= 3'd0;
			dout_on_r <= 1'b0;
			RD_READY  <= 1'b0;
			SO_O      <= 1'b0;
			SI_O      <= 1'b0;
			WP_N_O    <= 1'b0;
			HOLD_N_O  <= 1'b0;
		end else begin
			RD_READY <= load_out & ~is_getf & RD_VALID;
			if (state_r != SNFE_DOUT) begin
				out_cnt_r <= 3'd0;
				dout_on_r <= 1'b0;
			end else if (sck_fall) begin
				dout_on_r <= 1'b1;
				out_sh_r  <= cur_out << lane_w_r;
				out_cnt_r <= out_cnt_r + lane_w_r;
				case (lane_w_r)
					3'd4: begin
						HOLD_N_O <= cur_out[7];
						WP_N_O   <= cur_out[6];
						SO_O     <= cur_out[5];
						SI_O     <= cur_out[4];
					end
					3'd2: begin
						SO_O <= cur_out[7];
						SI_O <= cur_out[6];
					end
					default: begin
						SO_O <= cur_out[7];
					end
				endcase
			end
		end
	end

	// Enables drop while suspended; two system clocks behind the edge
	wire drive  = dout_on_r & ~hold_act_r & ~cs_n_s;
	wire wide2  = (lane_w_r != 3'd1);
	wire wide4  = (lane_w_r == 3'd4);

	always_ff @(posedge SYS_CLK) begin
		if (SRST) begin
			SO_OE     <= 1'b0;
			SI_OE     <= 1'b0;
			WP_N_OE   <= 1'b0;
			HOLD_N_OE <= 1'b0;
		end else begin
			SO_OE     <= drive;
			SI_OE     <= drive & wide2;
			WP_N_OE   <= drive & wide4;
			HOLD_N_OE <= drive & wide4;
		end
	end

	assign LOCK_FEAT = lock_r;

	snfe_fifo #(
		.WIDTH ($bits(snfe_wr_t)),
		.DEPTH (FIFO_DEPTH)
	) u_wr_fifo (
		.clk       (SYS_CLK),
		.srst      (SRST),
		.in_valid  (push_r),
		.in_ready  (fifo_ready),
		.in_data   (push_word_r),
		.out_valid (WR_VALID),
		.out_ready (WR_READY),
		.out_data  (WR)
	);
endmodule : snfe_top

//--- snfe_props.sv
`timescale 1ns/10ps
module snfe_props
	import snfe_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       SRST,
	input wire logic       CS_N,
	input wire logic       SCK,
	input wire logic       SO_OE,
	input wire logic       WP_N_I,
	input wire logic       WP_N_OE,
	input wire logic       HOLD_N_I,
	input wire logic       HOLD_N_OE,
	input wire logic       ECC_EN,
	input wire logic       CMD_VALID,
	input wire snfe_cmd_t  CMD,
	input wire logic       WR_VALID,
	input wire logic       WR_READY,
	input wire snfe_wr_t   WR,
	input wire logic [7:0] LOCK_FEAT
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SRST);
	logic [12:0] page_len;
	assign page_len = ECC_EN ? PAGE_LEN_ECC : PAGE_LEN_NOECC;
	// Six low cycles cover the pin sync lag
	sequence held_s;
		($fell(SCK) && !HOLD_N_I && !HOLD_N_OE && !CS_N)
			##1 (!HOLD_N_I && !SCK && !CS_N)[*6];
	endsequence
	chk_hold_float: assert property (held_s |-> !SO_OE)
		else $error("serial output driven while held");
	chk_cs_quiet: assert property (CS_N[*6] |-> !SO_OE)
		else $error("serial output driven while deselected");
	chk_cmd_pulse: assert property (CMD_VALID |=> !CMD_VALID)
		else $error("command strobe longer than one cycle");
	chk_erase_row: assert property (
		CMD_VALID && CMD.opcode == OP_BLK_ERASE |->
		CMD.has_row && !CMD.has_col && CMD.row_address.page_num == '0)
		else $error("erase command carries column or page");
	chk_col_range: assert property (
		CMD_VALID && CMD.has_col |->
		CMD.col_range_err == (CMD.column_address >= page_len))
		else $error("column range flag wrong for page length");
	chk_guard_bits: assert property (
		!WP_N_I && !WP_N_OE && LOCK_FEAT[LOCK_GUARD_POS] |=>
		((LOCK_FEAT ^ $past(LOCK_FEAT)) & FEAT_GUARD_MASK) == 8'h00)
		else $error("guarded lock bits changed while guarded");
	chk_wr_stall: assert property (
		WR_VALID && !WR_READY |=> WR_VALID && $stable(WR))
		else $error("write head lost while stalled");
	chk_lane_pair: assert property (WP_N_OE == HOLD_N_OE)
		else $error("upper lanes enabled apart");
	cov_hold: cover property (held_s);
	cov_col_err: cover property (CMD_VALID && CMD.col_range_err);
	cov_stall: cover property (WR_VALID && !WR_READY);
	cov_quad: cover property (HOLD_N_OE);
endmodule : snfe_props

bind snfe_top snfe_props u_props (
	.SYS_CLK, .SRST, .CS_N, .SCK, .SO_OE, .WP_N_I, .WP_N_OE,
	.HOLD_N_I, .HOLD_N_OE, .ECC_EN, .CMD_VALID, .CMD, .WR_VALID,
	.WR_READY, .WR, .LOCK_FEAT
);

//--- snfe_host_model.sv
`timescale 1ns/10ps
module snfe_host_model (
	input  wire logic clk,
	input  wire logic si_w,
	input  wire logic so_w,
	input  wire logic wp_w,
	input  wire logic hold_w,
	input  wire logic so_oe,
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      wp,
	output logic      wp_oe,
	output logic      hold,
	output logic      lane_oe
);
	int   lanes = 1;
	logic oe_held;
	logic oe_back;
	// Idle clock level picks the mode: low for 0, high for 3
	logic cpol = 1'b0;
	// Multi-lane reads: host lets go of guard and hold; in lane carries inverted si
	assign lane_oe = (lanes == 1);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		wp = 1'b1;
		wp_oe = 1'b1;
		hold = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt
	// Guard level only moves while deselected
	task automatic start(input logic lvl, input logic drv);
		sck = cpol;
		wp = lvl;
		wp_oe = drv;
		wt(2);
		cs_n = 1'b0;
		wt(4);
	endtask : start
	task automatic stop();
		cs_n = 1'b1;
		si = ~si;
		// Clock parks only after select is gone, so no stray edge
		wt(2);
		sck = cpol;
		wt(4);
	endtask : stop
	// Hold drops with clock high so the next fall starts it
	task automatic hold_seq();
		hold = 1'b0;
		wt(2);
		sck = 1'b0;
		wt(8);
		oe_held = so_oe;
		si = ~si;
		sck = 1'b1;
		wt(4);
		sck = 1'b0;
		wt(4);
		hold = 1'b1;
		wt(6);
		oe_back = so_oe;
	endtask : hold_seq
	// Mode 0, 800 ns clock, MSB first
	task automatic xfer(input logic [7:0] d, input int h,
		output logic [7:0] q);
		for (int i = 0; i < 8 / lanes; i++) begin
			sck = 1'b0;
			si = d[7-i];
			wt(4);
			case (lanes)
				4: q = {q[3:0], hold_w, wp_w, so_w, si_w};
				2: q = {q[5:0], so_w, si_w};
				default: q = {q[6:0], so_w};
			endcase
			sck = 1'b1;
			wt(4);
			if (i == h)
				hold_seq();
		end
	endtask : xfer
endmodule : snfe_host_model

//--- serial_nand_spi_front_end_test.sv
`timescale 1ns/10ps
module serial_nand_spi_front_end_test
	import snfe_pkg::*;
;
	logic      sys_clk, srst, ecc_en, wr_ready, rd_valid;
	logic      [7:0] rd_data, lock_feat;
	logic      si_o, si_oe, so_o, so_oe, wp_o, wp_oe, hold_o, hold_oe;
	logic      cmd_valid, wr_valid, wr_overrun, rd_ready;
	logic      h_cs_n, h_sck, h_si, h_wp, h_wp_oe, h_hold, lane_oe;
	wire logic si_w, so_w, wp_w, hold_w;
	snfe_cmd_t cmd, cmd_seen;
	snfe_wr_t  wr;
	int        cmd_cnt = 0;
	int        ovr_cnt = 0;
	int        rdy_cnt = 0;
	int        tests_run = 0;
	int        miscompares = 0;
	// Undriven guard and hold lines float high
	assign si_w = si_oe ? si_o : (lane_oe ? h_si : ~h_si);
	assign so_w = so_oe ? so_o : 1'bz;
	assign wp_w = wp_oe ? wp_o : (h_wp_oe && lane_oe ? h_wp : 1'b1);
	assign hold_w = hold_oe ? hold_o : (lane_oe ? h_hold : 1'b1);
	snfe_top uut (
		.SYS_CLK(sys_clk), .SRST(srst), .CS_N(h_cs_n), .SCK(h_sck),
		.SI_I(si_w), .SI_O(si_o), .SI_OE(si_oe), .SO_O(so_o), .SO_OE(so_oe),
		.WP_N_I(wp_w), .WP_N_O(wp_o), .WP_N_OE(wp_oe), .HOLD_N_I(hold_w),
		.HOLD_N_O(hold_o), .HOLD_N_OE(hold_oe), .ECC_EN(ecc_en),
		.CMD_VALID(cmd_valid), .CMD(cmd), .WR_VALID(wr_valid),
		.WR_READY(wr_ready), .WR(wr), .WR_OVERRUN(wr_overrun),
		.RD_VALID(rd_valid), .RD_READY(rd_ready), .RD_DATA(rd_data),
		.LOCK_FEAT(lock_feat)
	);
	snfe_host_model host (
		.clk(sys_clk), .si_w(si_w), .so_w(so_w), .wp_w(wp_w),
		.hold_w(hold_w), .so_oe(so_oe), .cs_n(h_cs_n), .sck(h_sck),
		.si(h_si), .wp(h_wp), .wp_oe(h_wp_oe), .hold(h_hold),
		.lane_oe(lane_oe)
	);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (cmd_valid === 1'b1) begin
			cmd_cnt++;
			cmd_seen = cmd;
		end
		if (wr_overrun === 1'b1)
			ovr_cnt++;
		if (rd_ready === 1'b1)
			rdy_cnt++;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic t_row(input logic [7:0] op, input logic [16:0] row,
		input logic [16:0] exp);
		int         n;
		logic [7:0] q;
		n = cmd_cnt;
		host.start(1'b1, 1'b1);
		host.xfer(op, 8, q);
		host.xfer({7'h7F, row[16]}, 8, q);
		host.xfer(row[15:8], 8, q);
		host.xfer(row[7:0], 8, q);
		host.stop();
		chk(cmd_cnt - n, 1);
		chk(cmd_seen.opcode, op);
		chk({cmd_seen.has_row, cmd_seen.has_col}, 2'b10);
		chk(cmd_seen.row_address, exp);
	endtask : t_row
	task automatic t_read(input logic [7:0] op, input logic [12:0] col,
		input logic ecc, input logic err, input int h, input int ln);
		logic [7:0] q;
		int         n;
		n = rdy_cnt;
		ecc_en = ecc;
		rd_valid = ecc;
		rd_data = op ^ col[7:0];
		host.start(1'b1, 1'b1);
		host.xfer(op, 8, q);
		host.xfer({3'h7, col[12:8]}, 8, q);
		host.xfer(col[7:0], h, q);
		host.xfer(8'hFF, 8, q);
		host.lanes = ln;
		host.xfer(8'h00, h, q);
		host.stop();
		host.lanes = 1;
		chk(q, ecc ? rd_data : 8'hFF);
		chk(rdy_cnt - n, ecc);
		chk(cmd_seen.column_address, col);
		chk(cmd_seen.col_range_err, err);
		if (h < 8)
			chk({host.oe_held, host.oe_back}, 2'b01);
	endtask : t_read
	task automatic t_feat(input logic wp, input logic drv,
		input logic [7:0] adr, input logic [7:0] d, input logic [7:0] exp);
		logic [7:0] q;
		host.start(wp, drv);
		host.xfer(OP_SET_FEAT, 8, q);
		host.xfer(adr, 8, q);
		host.xfer(d, 8, q);
		host.stop();
		chk(lock_feat, exp);
		host.start(1'b1, 1'b1);
		host.xfer(OP_GET_FEAT, 8, q);
		host.xfer(FEAT_LOCK_ADDR, 8, q);
		host.xfer(8'h00, 8, q);
		host.stop();
		chk(q, exp);
	endtask : t_feat
	// Unknown opcode: strobe carries the opcode, rest of frame ignored
	task automatic t_unk(input logic [7:0] op);
		int         n;
		logic [7:0] q;
		n = cmd_cnt;
		host.start(1'b1, 1'b1);
		host.xfer(op, 8, q);
		host.xfer(8'hFF, 8, q);
		host.xfer(8'hFF, 8, q);
		host.stop();
		chk(cmd_cnt - n, 1);
		chk(cmd_seen.opcode, op);
		chk({cmd_seen.has_row, cmd_seen.has_col}, 2'b00);
	endtask : t_unk
	// Host stalls the write side so the buffer fills; more bytes than it holds overflow
	task automatic t_prog(input logic [7:0] op, input logic [12:0] col,
		input int nb, input int ns, input int ovr);
		logic [7:0] q;
		int         n, k, t;
		n = ovr_cnt;
		ecc_en = 1'b1;
		wr_ready = 1'b0;
		host.start(1'b1, 1'b1);
		host.xfer(op, 8, q);
		host.xfer({3'h7, col[12:8]}, 8, q);
		host.xfer(col[7:0], 8, q);
		for (k = 0; k < nb; k++)
			host.xfer(8'h5A + 8'(k), 8, q);
		host.stop();
		chk(ovr_cnt - n, ovr);
		chk(cmd_seen.opcode, op);
		chk(cmd_seen.column_address, col);
		for (k = 0; k < ns; k++) begin
			for (t = 0; t < 20 && wr_valid !== 1'b1; t++)
				@(negedge sys_clk);
			if (t == 20) begin
				miscompares++;
				end_sim();
			end
			chk(wr, {col + 13'(k), 8'h5A + 8'(k)});
			wr_ready = 1'b1;
			@(negedge sys_clk);
			wr_ready = 1'b0;
		end
		repeat (4) @(negedge sys_clk);
		chk(wr_valid, 1'b0);
	endtask : t_prog
	initial begin
		repeat (100000) @(posedge sys_clk);
		miscompares++;
		end_sim();
	end
	initial begin
		srst = 1'b1;
		ecc_en = 1'b1;
		wr_ready = 1'b0;
		rd_valid = 1'b1;
		rd_data = 8'h00;
		repeat (2) @(negedge sys_clk);
		srst = 1'b0;
		chk(lock_feat, FEAT_LOCK_RST);
		chk({so_oe, si_oe, wp_oe, hold_oe, cmd_valid, wr_valid}, 6'h00);
		repeat (3) @(negedge sys_clk);
		t_row(OP_RD_ARRAY, 17'h1_FFFF, 17'h1_FFFF);
		t_row(OP_BLK_ERASE, 17'h0_0041, 17'h0_0040);
		host.cpol = 1'b1;
		t_row(OP_PRG_EXEC, 17'h0_0025, 17'h0_0025);
		host.cpol = 1'b0;
		t_unk(8'hA5);
		t_read(OP_RD_BUF, 13'h107F, 1'b1, 1'b0, 7, 1);
		t_read(OP_RD_BUF_F, 13'h1080, 1'b1, 1'b1, 8, 1);
		t_read(OP_RD_BUF, 13'h10FF, 1'b0, 1'b0, 8, 1);
		t_read(OP_RD_BUF_F, 13'h1100, 1'b0, 1'b1, 8, 1);
		t_read(OP_RD_BUF_X2, 13'h0003, 1'b1, 1'b0, 8, 2);
		t_read(OP_RD_BUF_X4, 13'h0000, 1'b1, 1'b0, 8, 4);
		t_feat(1'b1, 1'b1, FEAT_LOCK_ADDR, 8'hB8, 8'hB8);
		t_feat(1'b0, 1'b1, FEAT_LOCK_ADDR, 8'h06, 8'hBE);
		t_feat(1'b1, 1'b0, FEAT_LOCK_ADDR, 8'h00, 8'h00);
		t_feat(1'b0, 1'b1, FEAT_LOCK_ADDR, 8'h38, 8'h38);
		t_feat(1'b1, 1'b1, 8'hB0, 8'hFF, 8'h38);
		t_feat(1'b1, 1'b1, FEAT_LOCK_ADDR, 8'h00, 8'h00);
		t_prog(OP_PRG_LOAD, 13'h0FFA, 9, 8, 1);
		t_prog(OP_PRG_RAND, 13'h107F, 2, 1, 0);
		end_sim();
	end
endmodule : serial_nand_spi_front_end_test
